// ==== verilog/rtcirq_defs.vh ====
// Constants for the RTC interrupt, rate and update control block
//
// Functional notes
// - Events set their flags regardless of enables
// - Enable bits 6,5,4 gate flags onto request
// - Already set flag asserts request when enabled
// - Flag read returns then clears all flags
// - Events during flag read held until after
// - Request low while any flag and enable
// - Summary flag mirrors request line state
// - One rate code feeds periodic and square wave
// - Rate table: none, 256, 128, 8192 halving
// - Square wave only while its enable set
// - Alarm compares hours, minutes, seconds each update
// - Alarm bytes C0 to FF match anything
// - Update flag each update; freeze blocks request
// - Code 010 runs, 11X holds chain reset
// - First update 500 ms after code 010
// - Counters advance; freeze holds visible copy
// - Update flag rises, transfer 244 us later
// - Flag low means 244 us until transfer
// - Update flag read only, freeze clears it
// - Rate bits read/write, kept through reset
// - Periodic flag set on selected tap edge
// - Update enable cleared by reset or freeze
`ifndef RTCIRQ_DEFS_VH
`define RTCIRQ_DEFS_VH
// Register index values
`define RTCIRQ_REG_RATE     2'h0
`define RTCIRQ_REG_CTRL     2'h1
`define RTCIRQ_REG_FLAG     2'h2
// Field positions
`define RTCIRQ_BIT_UPD_PEND 7
`define RTCIRQ_BIT_FREEZE   7
`define RTCIRQ_BIT_PIE      6
`define RTCIRQ_BIT_AIE      5
`define RTCIRQ_BIT_UIE      4
`define RTCIRQ_BIT_SQUARE_WAVE_ENABLE     3
`define RTCIRQ_BIT_IRQ_SUMMARY_FLAG     7
`define RTCIRQ_BIT_PF       6
`define RTCIRQ_BIT_AF       5
`define RTCIRQ_BIT_UF       4
// Reset and code values
`define RTCIRQ_RST_OSC      3'h0
`define RTCIRQ_RST_CTRL     8'h00
`define RTCIRQ_OSC_RUN      3'h2
`define RTCIRQ_DONT_CARE    2'h3
// Timing
`define RTCIRQ_CLK_MHZ      250
`define RTCIRQ_PRE_UPD_US   244
`define RTCIRQ_FIRST_UPD_MS 500
`define RTCIRQ_UPD_CYC_US   1
`define RTCIRQ_TB_HZ        32768
`endif

// ==== verilog/rtcirq_tap_sel.v ====
// Divider tap selector for periodic rate and square wave
`timescale 1ns/10ps
module rtcirq_tap_sel (
  // Divider chain
  input  wire [14:0] div_cnt,
  // Rate selection
  input  wire [3:0]  rate_select,
  // Selected tap level
  output reg         tap_out
);
  // Map rate code to divider stage; 0000 gives constant low
  always @*
  begin
    tap_out = 1'b0;
    case (rate_select)
      4'h0: tap_out = 1'b0;
      4'h1: tap_out = div_cnt[6];
      4'h2: tap_out = div_cnt[7];
      default: tap_out = div_cnt[rate_select - 4'h2];
    endcase
  end
endmodule // rtcirq_tap_sel

// ==== verilog/rtcirq_alarm_cmp.v ====
// Alarm byte comparison with don't care codes
`timescale 1ns/10ps
`include "rtcirq_defs.vh"
module rtcirq_alarm_cmp (
  // Time counters
  input  wire [23:0] time_hms,
  // Alarm bytes
  input  wire [23:0] alarm_hms,
  // Full match
  output wire        match
);
  wire [2:0] hit;
  genvar i;
  // Per byte compare, top two bits set means wildcard
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_byte
      assign hit[i] = (alarm_hms[8*i+7:8*i+6] == `RTCIRQ_DONT_CARE) ||
                      (alarm_hms[8*i+7:8*i] == time_hms[8*i+7:8*i]);
    end
  endgenerate
  assign match = &hit;
endmodule // rtcirq_alarm_cmp

// ==== verilog/rtcirq_top.v ====
// Interrupt, rate select, oscillator and update status control
`timescale 1ns/10ps
`include "rtcirq_defs.vh"
module rtcirq_top #(
  parameter integer PRE_UPD_CYC   = `RTCIRQ_PRE_UPD_US * `RTCIRQ_CLK_MHZ,
  parameter integer FIRST_UPD_CYC = `RTCIRQ_FIRST_UPD_MS * 1000 *
                                    `RTCIRQ_CLK_MHZ,
  parameter integer UPD_CYC       = `RTCIRQ_UPD_CYC_US * `RTCIRQ_CLK_MHZ,
  parameter integer TB_DIV        = (`RTCIRQ_CLK_MHZ * 1000000) /
                                    `RTCIRQ_TB_HZ,
  parameter integer SEC_TICKS     = `RTCIRQ_TB_HZ
) (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // Register port
  input  wire        reg_sel,
  input  wire [1:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Time and alarm bytes
  input  wire [23:0] time_hms,
  input  wire [23:0] alarm_hms,
  // Timing strobes to the calendar
  output reg         count_advance,
  output reg         update_transfer,
  output wire        time_freeze,
  output wire        osc_on,
  // Pins
  output wire        irq_n,
  output reg         square_wave_out
);
  localparam [31:0] PRE_W   = PRE_UPD_CYC;
  localparam [31:0] FIRST_W = FIRST_UPD_CYC;
  localparam [31:0] UPD_W   = UPD_CYC;
  localparam [31:0] TBD_W   = TB_DIV;
  localparam [31:0] SEC_W   = SEC_TICKS;
  // One-hot update states
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_PEND = 4'h2;
  localparam [3:0] S_UPD  = 4'h4;
  localparam [3:0] S_WAIT = 4'h8;

  reg  [2:0]  osc_r;
  reg  [3:0]  rate_r;
  reg  [7:0]  ctrl_r;
  reg  [2:0]  flag_r;
  reg  [2:0]  held_r;
  reg         rd_active_r;
  reg  [31:0] tb_cnt_r;
  reg  [14:0] div_r;
  reg         tap_d_r;
  reg  [31:0] sec_cnt_r;
  reg  [31:0] dly_r;
  reg  [3:0]  st_r;
  reg         pend_r;
  reg         running_r;
  wire        tap;
  wire        alarm_hit;
  wire        irq_act;
  wire        flag_rd;
  wire        chain_run;
  wire        tb_tick;
  wire        tap_edge;
  wire        sec_evt;
  wire [2:0]  evt;
  reg         upd_end;
  reg         alarm_evt;
  wire        freeze_wr;

  // Rate tap selection
  rtcirq_tap_sel u_tap (
    .div_cnt     (div_r),
    .rate_select (rate_r),
    .tap_out     (tap)
  );

  // Alarm comparator
  rtcirq_alarm_cmp u_alarm (
    .time_hms  (time_hms),
    .alarm_hms (alarm_hms),
    .match     (alarm_hit)
  );

  assign flag_rd   = reg_sel && reg_rd && (reg_addr == `RTCIRQ_REG_FLAG);
  assign freeze_wr = reg_sel && reg_wr && (reg_addr == `RTCIRQ_REG_CTRL) &&
                     reg_wdata[`RTCIRQ_BIT_FREEZE];
  assign time_freeze = ctrl_r[`RTCIRQ_BIT_FREEZE];
  assign osc_on    = (osc_r == `RTCIRQ_OSC_RUN) || (osc_r[2:1] == 2'h3);
  assign chain_run = (osc_r == `RTCIRQ_OSC_RUN);

  // Rate and oscillator register; rate bits have no reset
  always @(posedge clk)
  begin
    if (reg_sel && reg_wr && (reg_addr == `RTCIRQ_REG_RATE))
      rate_r <= reg_wdata[3:0];
  end

  // Oscillator code, cleared to off at reset
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      osc_r <= `RTCIRQ_RST_OSC;
    else if (reg_sel && reg_wr && (reg_addr == `RTCIRQ_REG_RATE))
      osc_r <= reg_wdata[6:4];
  end

  // Control register; freeze going high drops update enable
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_r <= `RTCIRQ_RST_CTRL;
    else if (reg_sel && reg_wr && (reg_addr == `RTCIRQ_REG_CTRL))
    begin
      ctrl_r <= reg_wdata;
      if (reg_wdata[`RTCIRQ_BIT_FREEZE] && !ctrl_r[`RTCIRQ_BIT_FREEZE])
        ctrl_r[`RTCIRQ_BIT_UIE] <= 1'b0;
    end
  end

  // Time base tick from system clock
  assign tb_tick = osc_on && (tb_cnt_r == TBD_W - 32'h1);
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tb_cnt_r <= 32'h0;
    else if (!osc_on || tb_tick)
      tb_cnt_r <= 32'h0;
    else
      tb_cnt_r <= tb_cnt_r + 32'h1;
  end

  // Countdown chain, held in reset unless code 010
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      div_r <= 15'h0;
    else if (!chain_run)
      div_r <= 15'h0;
    else if (tb_tick)
      div_r <= div_r + 15'h1;
  end

  // Tap edge detect for the periodic flag
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tap_d_r <= 1'b0;
    else
      tap_d_r <= tap;
  end
  assign tap_edge = tap && !tap_d_r && (rate_r != 4'h0);

  // Square wave pin gated by its enable
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      square_wave_out <= 1'b0;
    else
      square_wave_out <= tap && ctrl_r[`RTCIRQ_BIT_SQUARE_WAVE_ENABLE];
  end

  // Seconds counter; first second lasts 500 ms after start
  assign sec_evt = chain_run && tb_tick && (sec_cnt_r == SEC_W - 32'h1);
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sec_cnt_r <= 32'h0;
      running_r <= 1'b0;
    end
    else if (!chain_run)
    begin
      sec_cnt_r <= SEC_W >> 1;
      running_r <= 1'b0;
    end
    else
    begin
      running_r <= 1'b1;
      if (tb_tick)
        sec_cnt_r <= sec_evt ? 32'h0 : sec_cnt_r + 32'h1;
    end
  end

  // Update sequencer: pending flag, transfer after delay, end
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r            <= S_IDLE;
      dly_r           <= 32'h0;
      count_advance   <= 1'b0;
      update_transfer <= 1'b0;
      upd_end         <= 1'b0;
      alarm_evt       <= 1'b0;
    end
    else
    begin
      count_advance   <= 1'b0;
      update_transfer <= 1'b0;
      upd_end         <= 1'b0;
      alarm_evt       <= 1'b0;
      case (st_r)
        S_IDLE:
        begin
          if (sec_evt && running_r)
          begin
            st_r  <= S_PEND;
            dly_r <= 32'h0;
          end
        end
        S_PEND:
        begin
          if (dly_r == PRE_W - 32'h1)
          begin
            st_r            <= S_UPD;
            dly_r           <= 32'h0;
            count_advance   <= 1'b1;
            update_transfer <= !time_freeze;
          end
          else
            dly_r <= dly_r + 32'h1;
        end
        S_UPD:
        begin
          if (dly_r == UPD_W - 32'h1)
          begin
            st_r      <= S_WAIT;
            upd_end   <= 1'b1;
            alarm_evt <= alarm_hit;
          end
          else
            dly_r <= dly_r + 32'h1;
        end
        S_WAIT:
          st_r <= S_IDLE;
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  // Visible pending flag; freeze write clears it, no reset
  always @(posedge clk)
  begin
    if (freeze_wr || time_freeze)
      pend_r <= 1'b0;
    else
      pend_r <= (st_r == S_PEND) || (st_r == S_UPD);
  end

  // Events: periodic, alarm, update ended
  assign evt = {tap_edge, alarm_evt, upd_end};

  // Read active marks every cycle of a read after its first
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rd_active_r <= 1'b0;
    else
      rd_active_r <= reg_sel && reg_rd;
  end

  // Flags with double latch; events during read are held
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flag_r <= 3'h0;
      held_r <= 3'h0;
    end
    else if (flag_rd)
    begin
      held_r <= held_r | evt;
      if (!rd_active_r)
        flag_r <= 3'h0;
    end
    else
    begin
      flag_r <= flag_r | held_r | evt;
      held_r <= 3'h0;
    end
  end

  // Request: any flag with its enable; freeze masks update source
  assign irq_act = (flag_r[2] && ctrl_r[`RTCIRQ_BIT_PIE]) ||
                   (flag_r[1] && ctrl_r[`RTCIRQ_BIT_AIE]) ||
                   (flag_r[0] && ctrl_r[`RTCIRQ_BIT_UIE] &&
                    !time_freeze);
  assign irq_n = !irq_act;

  // Read data, sampled at the start of a read and held
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_sel && reg_rd && !rd_active_r)
    begin
      if (reg_addr == `RTCIRQ_REG_RATE)
        reg_rdata <= {pend_r, osc_r, rate_r};
      else if (reg_addr == `RTCIRQ_REG_CTRL)
        reg_rdata <= ctrl_r;
      else if (reg_addr == `RTCIRQ_REG_FLAG)
        reg_rdata <= {irq_act, flag_r, 4'h0};
      else
        reg_rdata <= 8'h00;
    end
  end
endmodule // rtcirq_top

// ==== test/rtcirq_host_model.sv ====
// Host model driving the register port
`timescale 1ns/10ps
module rtcirq_host_model (
  // Clock
  input  wire       clk,
  // Register port
  output reg        reg_sel,
  output reg  [1:0] reg_addr,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata
);
  // Idle bus at time zero
  initial
  begin
    reg_sel = 1'b0;
    reg_addr = 2'h3;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One-cycle write, then the bus lines change
  task wr(input [1:0] a, input [7:0] d);
  begin
    @(negedge clk);
    reg_sel = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_sel = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  end
  endtask
  // Read with a gap after; handlers end with a flag read
  task rd(input [1:0] a, output [7:0] q);
  begin
    @(negedge clk);
    reg_sel = 1'b1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    q = reg_rdata;
    reg_sel = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk);
  end
  endtask
  // Read held for n cycles, data taken at the end
  task rd_long(input [1:0] a, input integer n, output [7:0] q);
    integer k;
  begin
    @(negedge clk);
    reg_sel = 1'b1;
    reg_rd = 1'b1;
    reg_addr = a;
    for (k = 0; k < n; k = k + 1)
      @(negedge clk);
    q = reg_rdata;
    reg_sel = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk);
  end
  endtask
endmodule // rtcirq_host_model

// ==== test/rtcirq_props.sv ====
// Port checker for rtcirq_top
`timescale 1ns/10ps
module rtcirq_props (
  // Clock and reset
  input wire       clk,
  input wire       resetn,
  // Register port
  input wire       reg_sel,
  input wire [1:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Strobes and pin
  input wire       count_advance,
  input wire       update_transfer,
  input wire       time_freeze,
  input wire       osc_on,
  input wire       irq_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Access decodes: flag read, control write, rate write
  wire fr = reg_sel && reg_rd && reg_addr == 2'h2;
  wire cw = reg_sel && reg_wr && reg_addr == 2'h1;
  wire aw = reg_sel && reg_wr && reg_addr == 2'h0;
  a_xfer_cause: assert property (
    update_transfer |-> count_advance && !$past(time_freeze))
    else $error("transfer without advance or while frozen");
  a_xfer_free: assert property (
    count_advance && !$past(time_freeze) |-> update_transfer)
    else $error("advance without transfer while not frozen");
  a_freeze_wr: assert property (
    cw |=> time_freeze == $past(reg_wdata[7]))
    else $error("freeze level not as written");
  a_osc_code: assert property (
    aw |=> osc_on == ($past(reg_wdata[6:4]) == 3'h2 ||
                      $past(reg_wdata[6:5]) == 2'h3))
    else $error("oscillator state not as coded");
  a_irq_summary_flag_mirror: assert property (
    fr && !$past(reg_rd) |=> reg_rdata[7] == !$past(irq_n))
    else $error("summary flag differs from request line");
  a_read_clears: assert property (
    fr && !$past(reg_rd) |=> irq_n && reg_rdata[3:0] == 4'h0)
    else $error("flag read did not clear request");
  a_rdata_hold: assert property (
    reg_sel && reg_rd && $past(reg_sel && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved during read");
  a_adv_gap: assert property (
    count_advance |=> !count_advance [*8])
    else $error("advances too close");
endmodule // rtcirq_props
bind rtcirq_top rtcirq_props u_rtcirq_props (
  .clk(clk), .resetn(resetn), .reg_sel(reg_sel), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .count_advance(count_advance),
  .update_transfer(update_transfer), .time_freeze(time_freeze),
  .osc_on(osc_on), .irq_n(irq_n));

// ==== test/rtcirq_top_test.sv ====
// Self-checking bench for rtcirq_top
`timescale 1ns/10ps
module rtcirq_top_test;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg  [23:0] time_hms = 24'h000000;
  reg  [23:0] alarm_hms = 24'h01C0C0;
  wire        reg_sel, reg_wr, reg_rd, adv, xfer, frz, osc, irq_n, sq;
  wire [1:0]  reg_addr;
  wire [7:0]  reg_wdata, reg_rdata;
  integer     mismatches = 0;
  integer     n_compared = 0;
  integer     xf, i, n;
  reg  [7:0]  q;
  // Clock at 4 ns
  always #2 clk = ~clk;
  rtcirq_top #(.PRE_UPD_CYC(20), .FIRST_UPD_CYC(16), .UPD_CYC(4),
    .TB_DIV(2), .SEC_TICKS(16)) u_rtcirq_top (.clk(clk), .resetn(resetn),
    .reg_sel(reg_sel), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .time_hms(time_hms), .alarm_hms(alarm_hms), .count_advance(adv),
    .update_transfer(xfer), .time_freeze(frz), .osc_on(osc),
    .irq_n(irq_n), .square_wave_out(sq));
  rtcirq_host_model u_rtcirq_host_model (.clk(clk), .reg_sel(reg_sel),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task stop_test;
  begin
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task chk(input [8*8-1:0] nm, input [7:0] e, input [7:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("ERROR %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // Wait for the next advance, counting transfers on the way
  task wait_adv;
  begin
    i = 0;
    while (adv !== 1'b1 && i < 200)
    begin
      @(negedge clk);
      i = i + 1;
      if (xfer === 1'b1) xf = xf + 1;
    end
    if (i == 200)
    begin
      mismatches = mismatches + 1;
      $display("ERROR adv_wait exp 1 got 0");
      stop_test;
    end
  end
  endtask
  // Wait for a second tick, then let the update finish
  task wait_upd;
  begin
    wait_adv;
    repeat (8) @(negedge clk);
  end
  endtask
  task s_reset;
  begin
    u_rtcirq_host_model.rd(2'h1, q);
    chk("ctrl", 8'h00, q);
    u_rtcirq_host_model.wr(2'h0, 8'h00);
    u_rtcirq_host_model.rd(2'h2, q);
    u_rtcirq_host_model.rd(2'h2, q);
    chk("flag0", 8'h00, q);
    u_rtcirq_host_model.wr(2'h3, 8'hFF);
    u_rtcirq_host_model.rd(2'h3, q);
    chk("idx3", 8'h00, q);
    chk("pins", 8'h01, {sq, osc, 5'h00, irq_n});
  end
  endtask
  task s_update;
  begin
    u_rtcirq_host_model.wr(2'h0, 8'h20);
    chk("osc", 8'h01, {7'h00, osc});
    xf = 0;
    wait_upd;
    chk("xfer_on", 8'h01, xf[7:0]);
    u_rtcirq_host_model.rd(2'h2, q);
    chk("flag1", 8'h10, q);
    alarm_hms = 24'hC0C0C0;
    wait_upd;
    u_rtcirq_host_model.rd(2'h2, q);
    chk("flag2", 8'h30, q);
    u_rtcirq_host_model.rd(2'h0, q);
    chk("rate", 8'h20, q & 8'h7F);
  end
  endtask
  task s_late_enable;
  begin
    wait_upd;
    chk("irq_off", 8'h01, {7'h00, irq_n});
    u_rtcirq_host_model.wr(2'h1, 8'h10);
    chk("irq_on", 8'h00, {7'h00, irq_n});
    u_rtcirq_host_model.rd(2'h2, q);
    chk("flag3", 8'hB0, q);
    chk("irq_clr", 8'h01, {7'h00, irq_n});
  end
  endtask
  task s_periodic;
  begin
    u_rtcirq_host_model.wr(2'h0, 8'h23);
    u_rtcirq_host_model.wr(2'h1, 8'h48);
    n = 0;
    for (i = 0; i < 60; i = i + 1)
    begin
      @(negedge clk);
      if (irq_n === 1'b0 && sq === 1'b1) n = n + 1;
    end
    chk("pf_sq", 8'h01, {7'h00, n > 0});
    u_rtcirq_host_model.wr(2'h1, 8'h00);
    repeat (2) @(negedge clk);
    chk("sq_off", 8'h00, {7'h00, sq});
    u_rtcirq_host_model.wr(2'h0, 8'h20);
    u_rtcirq_host_model.wr(2'h1, 8'h48);
    u_rtcirq_host_model.rd(2'h2, q);
    repeat (40) @(negedge clk);
    chk("sq_none", 8'h00, {7'h00, sq});
    u_rtcirq_host_model.rd(2'h2, q);
    chk("pf_none", 8'h00, q & 8'h40);
  end
  endtask
  // Update end inside a long flag read must survive it
  task s_hold;
  begin
    u_rtcirq_host_model.wr(2'h1, 8'h00);
    u_rtcirq_host_model.rd(2'h2, q);
    wait_adv;
    u_rtcirq_host_model.rd_long(2'h2, 10, q);
    u_rtcirq_host_model.rd(2'h2, q);
    chk("uf_held", 8'h10, q & 8'h10);
  end
  endtask
  task s_freeze;
  begin
    u_rtcirq_host_model.wr(2'h1, 8'h10);
    u_rtcirq_host_model.wr(2'h1, 8'h90);
    u_rtcirq_host_model.rd(2'h1, q);
    chk("uie_clr", 8'h80, q);
    chk("frz", 8'h01, {7'h00, frz});
    u_rtcirq_host_model.rd(2'h0, q);
    chk("pend", 8'h00, q & 8'h80);
    xf = 0;
    wait_upd;
    chk("xfer", 8'h00, xf[7:0]);
  end
  endtask
  task s_reset_keep;
  begin
    u_rtcirq_host_model.wr(2'h0, 8'h25);
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    chk("osc_rst", 8'h00, {7'h00, osc});
    u_rtcirq_host_model.rd(2'h0, q);
    chk("rs_keep", 8'h05, q & 8'h0F);
  end
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    xf = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    s_reset;
    s_update;
    s_late_enable;
    s_periodic;
    s_hold;
    s_freeze;
    s_reset_keep;
    stop_test;
  end
endmodule // rtcirq_top_test
